//--- include/pth_irq_pkg.sv
package pth_irq_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL   = 8'h20;
  localparam logic [7:0] IDX_SOURCE = 8'h25;
  localparam logic [7:0] IDX_CLEAR  = 8'h26;
  localparam logic [7:0] IDX_ENABLE = 8'h27;
  localparam logic [7:0] IDX_NONE   = 8'hff;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_W        = 5;
  localparam int SRC_W         = 2;
  localparam int SRC_LOW_BIT   = 0;
  localparam int SRC_HIGH_BIT  = 1;
  localparam int SRC_ACT_BIT   = 2;
  localparam int IDX_LSB       = 2;
  localparam int IDX_MSB       = 9;

  // ----------------------------------------------------------------
  // Reset values and the bus transfer code
  // ----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
  localparam logic [SRC_W-1:0]  SRC_RST    = 2'h0;
  localparam logic [SRC_W-1:0]  ENABLE_RST = 2'h3;
  localparam logic [1:0]        HTRANS_NSQ = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic autozero_reset;
    logic high_pressure_irq_enable;
    logic low_pressure_irq_enable;
    logic irq_latch_select;
    logic irq_master_enable;
  } ctrl_s;

  typedef struct packed {
    logic high;
    logic low;
  } src_s;

  typedef struct packed {
    ctrl_s       ctrl;
    src_s        src;
    logic [1:0]  irq_en;
    logic        irq;
    logic        dp_wr;
    logic [7:0]  dp_idx;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } state_s;

endpackage

//--- src/pressure_threshold_irq_cfg.sv
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps

// Functional notes
// - No pressure interrupt request while master enable is 0.
// - Latch select 1 holds requests in the source register; 0 passes them live.
// - Low enable 1 requests on pressure below threshold; 0 suppresses it.
// - High enable 1 requests on pressure above threshold; 0 suppresses it.
// - Writing 1 to autozero reset resets autozero; 0 keeps normal operation.
// - All control bits reset to zero: interrupts disabled and unlatched.
module pressure_threshold_irq_cfg
  import pth_irq_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        press_low,
  input  wire logic        press_high,
  output logic             irq,
  output logic             autozero_reset
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_s      s_reg;
  state_s      s_next;
  logic        ctrl_wr;
  logic        clr_wr;
  logic        en_wr;
  logic        ev_low;
  logic        ev_high;
  logic [7:0]  a_idx;
  logic [31:0] rd_val;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next  = s_reg;
    ctrl_wr = s_reg.dp_wr && (s_reg.dp_idx == IDX_CTRL);
    clr_wr  = s_reg.dp_wr && (s_reg.dp_idx == IDX_CLEAR);
    en_wr   = s_reg.dp_wr && (s_reg.dp_idx == IDX_ENABLE);
    rd_val  = 32'h0000_0000;
    a_idx   = IDX_NONE;

    // Self clearing, so a single write gives a one-cycle reset
    s_next.ctrl.autozero_reset = 1'b0;
    if (ctrl_wr) begin
      s_next.ctrl = ctrl_s'(hwdata[CTRL_W-1:0]);
    end
    if (en_wr) begin
      s_next.irq_en = hwdata[SRC_W-1:0];
    end

    // Gated by the control bits before the edge
    ev_low  = s_reg.ctrl.irq_master_enable && s_reg.ctrl.low_pressure_irq_enable && press_low;
    ev_high = s_reg.ctrl.irq_master_enable && s_reg.ctrl.high_pressure_irq_enable && press_high;

    // Set wins over a clear in the same cycle
    s_next.src.low  = ev_low | (s_reg.ctrl.irq_latch_select & s_reg.src.low
                      & ~(clr_wr & hwdata[SRC_LOW_BIT]));
    s_next.src.high = ev_high | (s_reg.ctrl.irq_latch_select & s_reg.src.high
                      & ~(clr_wr & hwdata[SRC_HIGH_BIT]));

    s_next.irq = s_next.ctrl.irq_master_enable && ((s_next.src & s_next.irq_en) != 2'h0);

    // Address phase; reads use post-write values to avoid a stale read after a write
    s_next.dp_wr = 1'b0;
    if (hsel && hready && (htrans == HTRANS_NSQ || htrans == 2'h3)) begin
      if (haddr[31:IDX_MSB+1] == '0) begin
        a_idx = haddr[IDX_MSB:IDX_LSB];
      end
      s_next.dp_wr  = hwrite;
      s_next.dp_idx = a_idx;
      if (!hwrite) begin
        unique case (a_idx)
          IDX_CTRL:   rd_val[CTRL_W-1:0] = s_next.ctrl;
          IDX_SOURCE: begin
            rd_val[SRC_W-1:0]   = s_next.src;
            rd_val[SRC_ACT_BIT] = s_next.src != 2'h0;
          end
          IDX_ENABLE: rd_val[SRC_W-1:0] = s_next.irq_en;
          default:    rd_val = 32'h0000_0000;
        endcase
        s_next.hrdata = rd_val;
      end
    end
    s_next.hreadyout = 1'b1;
    s_next.hresp     = 1'b0;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg.ctrl      <= ctrl_s'(CTRL_RST);
      s_reg.src       <= src_s'(SRC_RST);
      s_reg.irq_en    <= ENABLE_RST;
      s_reg.irq       <= 1'b0;
      s_reg.dp_wr     <= 1'b0;
      s_reg.dp_idx    <= IDX_NONE;
      s_reg.hrdata    <= 32'h0000_0000;
      s_reg.hreadyout <= 1'b1;
      s_reg.hresp     <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign hreadyout      = s_reg.hreadyout;
  assign hresp          = s_reg.hresp;
  assign hrdata         = s_reg.hrdata;
  assign irq            = s_reg.irq;
  assign autozero_reset = s_reg.ctrl.autozero_reset;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  no_irq_disabled_a: assert property (
    !s_reg.ctrl.irq_master_enable |-> !irq)
    else $error("Interrupt raised with master enable off");

  latch_hold_a: assert property (
    (s_reg.ctrl.irq_latch_select && s_reg.src.low && !(clr_wr && hwdata[SRC_LOW_BIT])) |=> s_reg.src.low)
    else $error("Latched low request lost without clear");

  unlatched_drop_a: assert property (
    (!s_reg.ctrl.irq_latch_select && !press_low) |=> !s_reg.src.low)
    else $error("Unlatched low request held");

  low_event_a: assert property (
    (s_reg.ctrl.irq_master_enable && s_reg.ctrl.low_pressure_irq_enable && press_low) |=> s_reg.src.low)
    else $error("Low pressure event not seen");

  high_suppress_a: assert property (
    (!s_reg.ctrl.high_pressure_irq_enable && !s_reg.src.high) |=> !s_reg.src.high)
    else $error("High pressure request while disabled");

  az_pulse_a: assert property (
    $rose(autozero_reset) |-> $past(ctrl_wr) ##1 (!autozero_reset || $past(ctrl_wr)))
    else $error("Autozero reset without write or not self clearing");

  reset_zero_a: assert property (
    $rose(hresetn) |-> (s_reg.ctrl == ctrl_s'(CTRL_RST)) && !irq)
    else $error("Control bits not zero after reset");

  irq_level_a: assert property (
    (s_reg.ctrl.irq_master_enable && s_reg.src.high && s_reg.irq_en[SRC_HIGH_BIT]) |-> irq)
    else $error("Interrupt low with enabled event active");

  gate_low_a: assert property (
    (!s_reg.ctrl.irq_master_enable && !s_reg.src.low) |=> !s_reg.src.low)
    else $error("Low request set with master enable off");

  gate_high_a: assert property (
    (!s_reg.ctrl.irq_master_enable && !s_reg.src.high) |=> !s_reg.src.high)
    else $error("High request set with master enable off");

  master_drop_a: assert property (
    $fell(s_reg.ctrl.irq_master_enable) |-> !irq)
    else $error("Interrupt kept after master enable cleared");

  latch_high_a: assert property (
    (s_reg.ctrl.irq_latch_select && s_reg.src.high && !(clr_wr && hwdata[SRC_HIGH_BIT])) |=> s_reg.src.high)
    else $error("Latched high request lost without clear");

  unlatched_high_a: assert property (
    (!s_reg.ctrl.irq_latch_select && !press_high) |=> !s_reg.src.high)
    else $error("Unlatched high request held");

  set_over_clear_a: assert property (
    (ev_low && clr_wr && hwdata[SRC_LOW_BIT]) |=> s_reg.src.low)
    else $error("Clear won over a new low request");

  clear_low_a: assert property (
    (clr_wr && hwdata[SRC_LOW_BIT] && !ev_low) |=> !s_reg.src.low)
    else $error("Low request not cleared");

  clear_high_a: assert property (
    (clr_wr && hwdata[SRC_HIGH_BIT] && !ev_high) |=> !s_reg.src.high)
    else $error("High request not cleared");

  low_suppress_a: assert property (
    (!s_reg.ctrl.low_pressure_irq_enable && !s_reg.src.low) |=> !s_reg.src.low)
    else $error("Low pressure request while disabled");

  high_event_a: assert property (
    (s_reg.ctrl.irq_master_enable && s_reg.ctrl.high_pressure_irq_enable && press_high) |=> s_reg.src.high)
    else $error("High pressure event not seen");

  high_live_a: assert property (
    (!s_reg.ctrl.high_pressure_irq_enable && !s_reg.ctrl.irq_latch_select) |=> !s_reg.src.high)
    else $error("Unlatched high request while disabled");

  az_source_a: assert property (
    autozero_reset |-> $past(ctrl_wr) && $past(hwdata[CTRL_W-1]))
    else $error("Autozero reset without a write of one");

  reset_src_a: assert property (
    $rose(hresetn) |-> (s_reg.src == src_s'(SRC_RST)) && !autozero_reset)
    else $error("Source or autozero not clear after reset");

  irq_low_level_a: assert property (
    (s_reg.ctrl.irq_master_enable && s_reg.src.low && s_reg.irq_en[SRC_LOW_BIT]) |-> irq)
    else $error("Interrupt low with enabled low event active");

  irq_quiet_a: assert property (
    ((s_reg.src & s_reg.irq_en) == 2'h0) |-> !irq)
    else $error("Interrupt high with no enabled event");

endmodule // pressure_threshold_irq_cfg

//--- tb/pressure_source.sv
`timescale 1ns/1ps

// ------------------------------------------
// Threshold comparator stand-in
// ------------------------------------------
module pressure_source (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic set_low,
  input  wire logic set_high,
  output logic      press_low,
  output logic      press_high
);
  // Levels are registered, as a real comparator updates once per sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      press_low  <= 1'b0;
      press_high <= 1'b0;
    end else begin
      press_low  <= set_low;
      press_high <= set_high;
    end
  end
endmodule // pressure_source

//--- tb/pressure_threshold_irq_cfg_tb.sv
`timescale 1ns/1ps

// ------------------------------------------
// Bench
// ------------------------------------------
module pressure_threshold_irq_cfg_tb;
  import pth_irq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, set_low, set_high;
  logic hreadyout, hresp, irq, autozero_reset, press_low, press_high;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  int n_mismatch, n_tests, k;
  assign hready = hreadyout;
  pressure_threshold_irq_cfg u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .press_low(press_low),
    .press_high(press_high), .irq(irq), .autozero_reset(autozero_reset));
  pressure_source u_src (.hclk(hclk), .hresetn(hresetn), .set_low(set_low), .set_high(set_high),
    .press_low(press_low), .press_high(press_high));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic end_sim;
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic rdy;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hreadyout !== 1'b1 && i < 50);
    if (hreadyout !== 1'b1) begin
      chk("hreadyout", 32'h1, {31'h0, hreadyout});
      end_sim;
    end
  endtask
  // Address phase, then data phase; no wait count assumed
  task automatic bus(input logic [7:0] idx, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NSQ;
    hwrite <= w;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input string s);
    bus(idx, 1'b0, 32'h0);
    chk(s, e, r);
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge hclk);
    @(negedge hclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  initial begin
    n_mismatch = 0;
    n_tests = 0;
    {hsel, hwrite, set_low, set_high} = 4'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_CTRL, 32'h0, "ctrl");
    rd(IDX_ENABLE, {30'h0, ENABLE_RST}, "enable");
    rd(IDX_SOURCE, 32'h0, "source");
    rd(8'hff, 32'h0, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    set_low <= 1'b1;
    irq_is(1'b0);
    bus(IDX_CTRL, 1'b1, 32'h5);
    irq_is(1'b1);
    rd(IDX_SOURCE, 32'h5, "source low");
    bus(IDX_CTRL, 1'b1, 32'h9);
    irq_is(1'b0);
    set_high <= 1'b1;
    irq_is(1'b1);
    bus(IDX_ENABLE, 1'b1, 32'h1);
    irq_is(1'b0);
    bus(IDX_ENABLE, 1'b1, 32'h3);
    bus(IDX_CTRL, 1'b1, 32'h1);
    irq_is(1'b0);
    bus(IDX_CTRL, 1'b1, 32'h9);
    irq_is(1'b1);
    set_high <= 1'b0;
    set_low <= 1'b0;
    irq_is(1'b0);
    bus(IDX_CTRL, 1'b1, 32'hb);
    @(posedge hclk) set_high <= 1'b1;
    @(posedge hclk) set_high <= 1'b0;
    irq_is(1'b1);
    rd(IDX_SOURCE, 32'h6, "source latched");
    bus(IDX_CLEAR, 1'b1, 32'h2);
    irq_is(1'b0);
    bus(IDX_CTRL, 1'b1, 32'h7);
    @(posedge hclk) set_low <= 1'b1;
    @(posedge hclk) set_low <= 1'b0;
    irq_is(1'b1);
    rd(IDX_SOURCE, 32'h5, "source low latched");
    bus(IDX_CLEAR, 1'b1, 32'h2);
    irq_is(1'b1);
    bus(IDX_CLEAR, 1'b1, 32'h1);
    irq_is(1'b0);
    k = 0;
    bus(IDX_CTRL, 1'b1, 32'h10);
    repeat (3) begin
      @(negedge hclk);
      k += (autozero_reset === 1'b1);
    end
    chk("autozero pulses", 32'h1, k);
    bus(IDX_CTRL, 1'b1, 32'h0);
    chk("autozero idle", 32'h0, {31'h0, autozero_reset});
    // Mid-run reset with a latched request must come back clean
    bus(IDX_CTRL, 1'b1, 32'hf);
    set_low <= 1'b1;
    irq_is(1'b1);
    @(posedge hclk) hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_CTRL, 32'h0, "ctrl after reset");
    rd(IDX_SOURCE, 32'h0, "source after reset");
    irq_is(1'b0);
    end_sim;
  end
endmodule // pressure_threshold_irq_cfg_tb
